// ### verilog/sfdp_pkg.sv
// package: constants, types and byte map of the discoverable parameter table
`default_nettype none
package sfdp_pkg;

    // ************************************************************
    // command and address space
    // ************************************************************
    localparam logic [7:0] SFDP_READ_OPCODE = 8'h5a;
    localparam int SFDP_ADDR_W = 24;
    localparam logic [7:0] SFDP_FILL_BYTE = 8'hff;

    // ************************************************************
    // fourth parameter header, bytes 20h..27h
    // ************************************************************
    localparam logic [23:0] SFDP_OFS_P4_ID_LOW = 24'h000020;
    localparam logic [23:0] SFDP_OFS_P4_MINOR_REV = 24'h000021;
    localparam logic [23:0] SFDP_OFS_P4_MAJOR_REV = 24'h000022;
    localparam logic [23:0] SFDP_OFS_P4_LENGTH = 24'h000023;
    localparam logic [23:0] SFDP_OFS_P4_PTR_BYTE0 = 24'h000024;
    localparam logic [23:0] SFDP_OFS_P4_PTR_BYTE1 = 24'h000025;
    localparam logic [23:0] SFDP_OFS_P4_PTR_BYTE2 = 24'h000026;
    localparam logic [23:0] SFDP_OFS_P4_ID_HIGH = 24'h000027;

    localparam logic [7:0] SFDP_VAL_P4_ID_LOW = 8'h87;
    localparam logic [7:0] SFDP_VAL_P4_MINOR_REV = 8'h00;
    localparam logic [7:0] SFDP_VAL_P4_MAJOR_REV = 8'h01;
    localparam logic [7:0] SFDP_VAL_P4_LENGTH = 8'h1c;
    localparam logic [7:0] SFDP_VAL_P4_PTR_BYTE0 = 8'h58;
    localparam logic [7:0] SFDP_VAL_P4_PTR_BYTE1 = 8'h01;
    localparam logic [7:0] SFDP_VAL_P4_PTR_BYTE2 = 8'h00;
    localparam logic [7:0] SFDP_VAL_P4_ID_HIGH = 8'hff;

    // ************************************************************
    // basic parameter words 1 to 4, bytes 100h..10dh
    // ************************************************************
    localparam logic [23:0] SFDP_OFS_W1_FLAGS = 24'h000100;
    localparam logic [23:0] SFDP_OFS_W1_ERASE4K_OPCODE = 24'h000101;
    localparam logic [23:0] SFDP_OFS_W1_READ_SUPPORT = 24'h000102;
    localparam logic [23:0] SFDP_OFS_W1_UNUSED = 24'h000103;
    localparam logic [23:0] SFDP_OFS_DENSITY_BYTE0 = 24'h000104;
    localparam logic [23:0] SFDP_OFS_DENSITY_BYTE1 = 24'h000105;
    localparam logic [23:0] SFDP_OFS_DENSITY_BYTE2 = 24'h000106;
    localparam logic [23:0] SFDP_OFS_DENSITY_BYTE3 = 24'h000107;
    localparam logic [23:0] SFDP_OFS_QUAD_IO_CYCLES = 24'h000108;
    localparam logic [23:0] SFDP_OFS_QUAD_IO_OPCODE = 24'h000109;
    localparam logic [23:0] SFDP_OFS_QUAD_OUT_CYCLES = 24'h00010a;
    localparam logic [23:0] SFDP_OFS_QUAD_OUT_OPCODE = 24'h00010b;
    localparam logic [23:0] SFDP_OFS_DUAL_OUT_CYCLES = 24'h00010c;
    localparam logic [23:0] SFDP_OFS_DUAL_OUT_OPCODE = 24'h00010d;

    localparam logic [7:0] SFDP_VAL_W1_FLAGS = 8'he7;
    localparam logic [7:0] SFDP_VAL_W1_ERASE4K_OPCODE = 8'h20;
    localparam logic [7:0] SFDP_VAL_W1_READ_SUPPORT = 8'hfa;
    localparam logic [7:0] SFDP_VAL_W1_UNUSED = 8'hff;
    localparam logic [7:0] SFDP_VAL_DENSITY_LOW = 8'hff;
    localparam logic [7:0] SFDP_VAL_DENSITY_TOP_256M = 8'h0f;
    localparam logic [7:0] SFDP_VAL_DENSITY_TOP_512M = 8'h1f;
    localparam logic [7:0] SFDP_VAL_DENSITY_TOP_1G = 8'h3f;
    localparam logic [7:0] SFDP_VAL_QUAD_IO_CYCLES = 8'h48;
    localparam logic [7:0] SFDP_VAL_QUAD_IO_OPCODE = 8'heb;
    localparam logic [7:0] SFDP_VAL_QUAD_OUT_CYCLES = 8'h08;
    localparam logic [7:0] SFDP_VAL_QUAD_OUT_OPCODE = 8'h6b;
    localparam logic [7:0] SFDP_VAL_DUAL_OUT_CYCLES = 8'h00;
    localparam logic [7:0] SFDP_VAL_DUAL_OUT_OPCODE = 8'hff;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        SFDP_DENS_256M,
        SFDP_DENS_512M,
        SFDP_DENS_1G,
        SFDP_DENS_RSVD
    } sfdp_density_t;

    // one command from the serial front end
    typedef struct packed {
        logic start;
        logic [7:0] opcode;
        logic [23:0] addr;
    } sfdp_cmd_t;

    // byte handed back to the serial front end
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sfdp_rsp_t;

endpackage : sfdp_pkg
`default_nettype wire

// ### verilog/sfdp_parameter_rom.sv
// module: byte server for the discoverable parameter table
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RULE_01: byte 20h returns 87h, the register map parameter identifier low byte.
// RULE_02: bytes 21h and 22h return revision 00h minor and 01h major.
// RULE_03: byte 23h returns 1Ch, a 28 word parameter table length.
// RULE_04: bytes 24h to 26h return 58h 01h 00h, pointer 158h little endian.
// RULE_05: byte 27h returns FFh, the parameter identifier high byte.
// RULE_06: byte 100h returns E7h, first basic word flag byte.
// RULE_07: byte 101h returns 20h, the 4KB erase opcode.
// RULE_08: byte 102h returns FAh, supported read protocols and address width.
// RULE_09: byte 103h returns FFh, unused top byte of word one.
// RULE_10: bytes 104h-106h return FFh; 107h returns 0Fh, 1Fh or 3Fh by density.
// RULE_11: byte 108h returns 48h, quad io mode and dummy cycles.
// RULE_12: byte 109h returns EBh, the quad io read opcode.
// RULE_13: byte 10Ah returns 08h, quad output mode and dummy cycles.
// RULE_14: byte 10Bh returns 6Bh, the quad output read opcode.
// RULE_15: byte 10Ch returns 00h and byte 10Dh returns FFh for dual output.
// RULE_16: two independent tables; one varies with the density option.
// RULE_17: reads use opcode 5Ah and address the table from byte zero.
// RULE_18: bytes come from a fixed lookup; each delivered byte advances address.
module sfdp_parameter_rom
    import sfdp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire sfdp_cmd_t cmd_i,
    input wire logic byte_ack_i,
    input wire logic cmd_end_i,
    input wire sfdp_density_t density_sel_i,
    output sfdp_rsp_t rsp_o,
    output logic [23:0] addr_o
);

    // ************************************************************
    // lookup
    // ************************************************************

    // density dependent top byte of the zero based bit count
    function automatic logic [7:0] sfdp_density_top(input sfdp_density_t sel);
        logic [7:0] v;
        v = SFDP_VAL_DENSITY_TOP_256M;
        case (sel)
            SFDP_DENS_512M: v = SFDP_VAL_DENSITY_TOP_512M;
            SFDP_DENS_1G: v = SFDP_VAL_DENSITY_TOP_1G;
            default: v = SFDP_VAL_DENSITY_TOP_256M; // reserved code reads as smallest part
        endcase
        return v;
    endfunction : sfdp_density_top

    // fixed byte map; neighbouring tables live elsewhere, so anything
    // outside the covered ranges reads as erased fill
    function automatic logic [7:0] sfdp_lookup(input logic [23:0] a, input sfdp_density_t sel);
        logic [7:0] v;
        v = SFDP_FILL_BYTE;
        if (a == SFDP_OFS_P4_ID_LOW)
            v = SFDP_VAL_P4_ID_LOW; // [RULE_01]
        else if (a == SFDP_OFS_P4_MINOR_REV)
            v = SFDP_VAL_P4_MINOR_REV; // [RULE_02]
        else if (a == SFDP_OFS_P4_MAJOR_REV)
            v = SFDP_VAL_P4_MAJOR_REV; // [RULE_02]
        else if (a == SFDP_OFS_P4_LENGTH)
            v = SFDP_VAL_P4_LENGTH; // [RULE_03]
        else if (a == SFDP_OFS_P4_PTR_BYTE0)
            v = SFDP_VAL_P4_PTR_BYTE0; // [RULE_04]
        else if (a == SFDP_OFS_P4_PTR_BYTE1)
            v = SFDP_VAL_P4_PTR_BYTE1; // [RULE_04]
        else if (a == SFDP_OFS_P4_PTR_BYTE2)
            v = SFDP_VAL_P4_PTR_BYTE2; // [RULE_04]
        else if (a == SFDP_OFS_P4_ID_HIGH)
            v = SFDP_VAL_P4_ID_HIGH; // [RULE_05]
        else if (a == SFDP_OFS_W1_FLAGS)
            v = SFDP_VAL_W1_FLAGS; // [RULE_06]
        else if (a == SFDP_OFS_W1_ERASE4K_OPCODE)
            v = SFDP_VAL_W1_ERASE4K_OPCODE; // [RULE_07]
        else if (a == SFDP_OFS_W1_READ_SUPPORT)
            v = SFDP_VAL_W1_READ_SUPPORT; // [RULE_08]
        else if (a == SFDP_OFS_W1_UNUSED)
            v = SFDP_VAL_W1_UNUSED; // [RULE_09]
        else if (a == SFDP_OFS_DENSITY_BYTE0)
            v = SFDP_VAL_DENSITY_LOW; // [RULE_10]
        else if (a == SFDP_OFS_DENSITY_BYTE1)
            v = SFDP_VAL_DENSITY_LOW; // [RULE_10]
        else if (a == SFDP_OFS_DENSITY_BYTE2)
            v = SFDP_VAL_DENSITY_LOW; // [RULE_10]
        else if (a == SFDP_OFS_DENSITY_BYTE3)
            v = sfdp_density_top(sel); // [RULE_10] [RULE_16]
        else if (a == SFDP_OFS_QUAD_IO_CYCLES)
            v = SFDP_VAL_QUAD_IO_CYCLES; // [RULE_11]
        else if (a == SFDP_OFS_QUAD_IO_OPCODE)
            v = SFDP_VAL_QUAD_IO_OPCODE; // [RULE_12]
        else if (a == SFDP_OFS_QUAD_OUT_CYCLES)
            v = SFDP_VAL_QUAD_OUT_CYCLES; // [RULE_13]
        else if (a == SFDP_OFS_QUAD_OUT_OPCODE)
            v = SFDP_VAL_QUAD_OUT_OPCODE; // [RULE_14]
        else if (a == SFDP_OFS_DUAL_OUT_CYCLES)
            v = SFDP_VAL_DUAL_OUT_CYCLES; // [RULE_15]
        else if (a == SFDP_OFS_DUAL_OUT_OPCODE)
            v = SFDP_VAL_DUAL_OUT_OPCODE; // [RULE_15]
        return v;
    endfunction : sfdp_lookup

    // ************************************************************
    // state
    // ************************************************************

    typedef enum logic [0:0] {
        SFDP_ST_IDLE,
        SFDP_ST_SERVE
    } sfdp_state_t;

    typedef struct packed {
        sfdp_state_t st;
        logic [23:0] addr;
        logic [7:0] data;
        logic valid;
    } sfdp_regs_t;

    sfdp_regs_t regs_q;
    sfdp_regs_t regs_d;

    // next state: a new 5Ah command always restarts, even mid-stream, so a
    // front end that lost a deselect cannot leave a stale address behind
    always_comb
    begin
        regs_d = regs_q;
        case (regs_q.st)
            SFDP_ST_IDLE:
            begin
                regs_d.valid = 1'b0;
            end
            SFDP_ST_SERVE:
            begin
                if (cmd_end_i)
                begin
                    regs_d.st = SFDP_ST_IDLE;
                    regs_d.valid = 1'b0;
                end
                else if (byte_ack_i)
                begin
                    // 24 bit address wraps at the top of the space
                    regs_d.addr = regs_q.addr + 24'h000001; // [RULE_18]
                    regs_d.data = sfdp_lookup(regs_d.addr, density_sel_i); // [RULE_18]
                end
                else
                begin
                    // keep the byte current if the density strap moves
                    regs_d.data = sfdp_lookup(regs_q.addr, density_sel_i);
                end
            end
            default:
            begin
                regs_d.st = SFDP_ST_IDLE;
                regs_d.valid = 1'b0;
            end
        endcase
        // only the discoverable read opcode opens the table
        if (cmd_i.start && (cmd_i.opcode == SFDP_READ_OPCODE)) // [RULE_17]
        begin
            regs_d.st = SFDP_ST_SERVE;
            regs_d.addr = cmd_i.addr; // [RULE_17]
            regs_d.data = sfdp_lookup(cmd_i.addr, density_sel_i); // [RULE_18]
            regs_d.valid = 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            regs_q.st <= SFDP_ST_IDLE;
            regs_q.addr <= 24'h000000;
            regs_q.data <= 8'h00;
            regs_q.valid <= 1'b0;
        end
        else
        begin
            regs_q <= regs_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // straight from the state flops
    assign rsp_o.valid = regs_q.valid;
    assign rsp_o.data = regs_q.data;
    assign addr_o = regs_q.addr;

endmodule : sfdp_parameter_rom
`default_nettype wire

// ### dv/sfdp_host_model.sv
// host controller model issuing discoverable-parameter reads
`timescale 1ns/100ps
`default_nettype none
module sfdp_host_model
    import sfdp_pkg::*;
(
    input wire logic clk_i,
    input wire sfdp_rsp_t rsp_i,
    input wire logic [23:0] addr_i,
    output var sfdp_cmd_t cmd_o,
    output logic ack_o,
    output logic end_o
);
    logic [32:0] got[$];
    initial
    begin
        cmd_o = '0;
        ack_o = 1'b0;
        end_o = 1'b0;
    end
    // start, back-to-back acks, deselect; samples land 1ns after each edge
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
        got.delete();
        @(posedge clk_i) cmd_o <= '{1'b1, op, a};
        // released fields are inverted so a stale value never passes
        @(posedge clk_i) cmd_o <= '{1'b0, ~op, ~a};
        ack_o <= (n > 1);
        for (int i = 0; i < n; i++)
        begin
            #1 got.push_back({addr_i, rsp_i});
            @(posedge clk_i) ack_o <= (i + 2 < n);
        end
        end_o <= 1'b1;
        @(posedge clk_i) end_o <= 1'b0;
        #1 got.push_back({addr_i, rsp_i});
    endtask : rd
endmodule : sfdp_host_model
`default_nettype wire

// ### dv/sfdp_rom_chk.sv
// checker: port assertions of the parameter byte server
`timescale 1ns/100ps
`default_nettype none
module sfdp_rom_chk
    import sfdp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire sfdp_cmd_t cmd_i,
    input wire logic byte_ack_i,
    input wire logic cmd_end_i,
    input wire sfdp_density_t density_sel_i,
    input wire sfdp_rsp_t rsp_o,
    input wire logic [23:0] addr_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // accepted start, and a plain advance with nothing competing
    sequence s_take; cmd_i.start && cmd_i.opcode == 8'h5a; endsequence
    sequence s_adv; rsp_o.valid && byte_ack_i && !cmd_i.start && !cmd_end_i; endsequence
    property p_take; s_take |=> rsp_o.valid && addr_o == $past(cmd_i.addr); endproperty
    property p_adv; s_adv |=> addr_o == $past(addr_o) + 24'h1; endproperty
    property p_end; rsp_o.valid && cmd_end_i && !cmd_i.start |=> !rsp_o.valid; endproperty
    property p_refuse; !rsp_o.valid && cmd_i.start && cmd_i.opcode != 8'h5a |=> !rsp_o.valid;
    endproperty
    property p_hold; rsp_o.valid && !byte_ack_i && !cmd_i.start && !cmd_end_i
        |=> rsp_o.valid && $stable(addr_o); endproperty
    property p_id; rsp_o.valid && addr_o == 24'h20 |-> rsp_o.data == 8'h87; endproperty
    property p_len; rsp_o.valid && addr_o == 24'h23 |-> rsp_o.data == 8'h1c; endproperty
    property p_ptr; rsp_o.valid && addr_o == 24'h24 |-> rsp_o.data == 8'h58; endproperty
    property p_dens; rsp_o.valid && addr_o == 24'h107 && density_sel_i == SFDP_DENS_1G
        && $stable(density_sel_i) |-> rsp_o.data == 8'h3f; endproperty
    property p_qio; rsp_o.valid && addr_o == 24'h109 |-> rsp_o.data == 8'heb; endproperty
    a_take: assert property (p_take) else $error("start not answered");
    a_adv: assert property (p_adv) else $error("ack did not advance");
    a_end: assert property (p_end) else $error("end did not drop valid");
    a_refuse: assert property (p_refuse) else $error("bad opcode taken");
    a_hold: assert property (p_hold) else $error("address moved");
    a_id: assert property (p_id) else $error("id byte wrong");
    a_len: assert property (p_len) else $error("length byte wrong");
    a_ptr: assert property (p_ptr) else $error("pointer byte wrong");
    a_dens: assert property (p_dens) else $error("density byte wrong");
    a_qio: assert property (p_qio) else $error("quad opcode wrong");
endmodule : sfdp_rom_chk
bind sfdp_parameter_rom sfdp_rom_chk i_sfdp_rom_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .cmd_i(cmd_i), .byte_ack_i(byte_ack_i), .cmd_end_i(cmd_end_i),
    .density_sel_i(density_sel_i), .rsp_o(rsp_o), .addr_o(addr_o));
`default_nettype wire

// ### dv/sfdp_parameter_rom_tb.sv
// testbench: reads the parameter bytes through the host model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module sfdp_parameter_rom_tb
    import sfdp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    sfdp_density_t dens = SFDP_DENS_256M;
    sfdp_cmd_t cmd;
    logic ack, cend;
    sfdp_rsp_t rsp;
    logic [23:0] addr;
    int fails = 0;
    int compares = 0;
    int seed = 32'h8f71b6c0;
    sfdp_parameter_rom i_sfdp_parameter_rom (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .cmd_i(cmd),
        .byte_ack_i(ack), .cmd_end_i(cend), .density_sel_i(dens), .rsp_o(rsp), .addr_o(addr));
    sfdp_host_model i_sfdp_host_model (.clk_i(sys_clk), .rsp_i(rsp), .addr_i(addr),
        .cmd_o(cmd), .ack_o(ack), .end_o(cend));
    initial forever #2 sys_clk = ~sys_clk;
    // expected byte; anything outside the two served ranges reads as fill
    function automatic logic [7:0] exp_b(input logic [23:0] a, input logic [1:0] d);
        logic [63:0] hdr;
        logic [111:0] bas;
        hdr = 64'h87_00_01_1c_58_01_00_ff;
        bas = 112'he7_20_fa_ff_ff_ff_ff_00_48_eb_08_6b_00_ff;
        if (a >= 24'h20 && a <= 24'h27) return hdr[8 * (24'h27 - a) +: 8];
        if (a == 24'h107) return (d == 2'd1) ? 8'h1f : (d == 2'd2) ? 8'h3f : 8'h0f;
        if (a >= 24'h100 && a <= 24'h10d) return bas[8 * (24'h10d - a) +: 8];
        return 8'hff;
    endfunction : exp_b
    // one read through the host, every delivered byte compared
    task automatic run(input logic [7:0] op, input logic [23:0] a, input int n);
        logic [23:0] ea;
        logic [32:0] g;
        i_sfdp_host_model.rd(op, a, n);
        for (int i = 0; i < n; i++)
        begin
            ea = a + i[23:0];
            g = i_sfdp_host_model.got[i];
            `CHK("valid", (op == 8'h5a), g[8])
            if (op == 8'h5a)
            begin
                `CHK("addr", ea, g[32:9])
                if (ea < 24'h100) `CHK("hdr", exp_b(ea, dens), g[7:0])
                else if (ea < 24'h104) `CHK("w1", exp_b(ea, dens), g[7:0])
                else `CHK("w2to4", exp_b(ea, dens), g[7:0])
            end
        end
        `CHK("ended", 1'b0, i_sfdp_host_model.got[n][8])
    endtask : run
    task automatic end_of_test;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        logic [31:0] r;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1 `CHK("rst valid", 1'b0, rsp.valid)
        // every density code across both full ranges
        for (int d = 0; d < 4; d++)
        begin
            @(posedge sys_clk) dens <= sfdp_density_t'(d);
            run(8'h5a, 24'h20, 8);
            run(8'h5a, 24'h100, 14);
        end
        run(8'h5b, 24'h20, 2);
        run(8'h5a, 24'hfffffe, 3);
        // random short reads clustered on the range edges
        for (int k = 0; k < 40; k++)
        begin
            r = $random(seed);
            @(posedge sys_clk) dens <= sfdp_density_t'(r[9:8]);
            run(8'h5a, r[10] ? {19'h0, r[4:0]} + 24'h1c : {19'h0, r[4:0]} + 24'hfc, 1 + r[2:0]);
        end
        end_of_test();
    end
    // bound on the whole run
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        end_of_test();
    end
endmodule : sfdp_parameter_rom_tb
`default_nettype wire
